/* logic/swrsl_defs.svh */
// Constants of the single-wire selection layer: command codes, timing figures, alarm map.
// Assumes a 125 MHz core clock; times are in nanoseconds.
`ifndef SWRSL_DEFS_SVH
`define SWRSL_DEFS_SVH

`define SWRSL_CLK_NS 8
`define SWRSL_CMD_READ 8'h33
`define SWRSL_CMD_MATCH 8'h55
`define SWRSL_CMD_SEARCH 8'hf0
`define SWRSL_CMD_CSEARCH 8'hec
`define SWRSL_CMD_SKIP 8'hcc
`define SWRSL_CMD_RESUME 8'ha5
`define SWRSL_CMD_ODSKIP 8'h3c
`define SWRSL_CMD_ODMATCH 8'h69
`define SWRSL_ALARM_OFFSET 16'h0214
`define SWRSL_ALARM_BROWNOUT_BIT 0
`define SWRSL_ALARM_FLAGS 5
// Standard speed timing.
`define SWRSL_STD_RESET_NS 480000
`define SWRSL_STD_PDH_NS 15000
`define SWRSL_STD_PDL_NS 60000
`define SWRSL_STD_SAMPLE_NS 30000
`define SWRSL_STD_HOLD_NS 30000
// Overdrive timing.
`define SWRSL_OD_RESET_NS 48000
`define SWRSL_OD_PDH_NS 2000
`define SWRSL_OD_PDL_NS 8000
`define SWRSL_OD_SAMPLE_NS 3000
`define SWRSL_OD_HOLD_NS 3000
// Low longer than this returns to standard speed.
`define SWRSL_OD_EXIT_NS 690000
`define SWRSL_CYC(ns) (((ns) + `SWRSL_CLK_NS - 1) / `SWRSL_CLK_NS)

`endif

/* logic/swrsl_pkg.sv */
// Types shared by the single-wire selection layer.
// Assumes swrsl_defs.svh is available on the include path.
package swrsl_pkg;

  typedef enum logic [3:0] {
    SWRSL_IDLE = 4'b0000,
    SWRSL_PRES_WAIT = 4'b0001,
    SWRSL_PRES_LOW = 4'b0010,
    SWRSL_CMD = 4'b0011,
    SWRSL_TX = 4'b0100,
    SWRSL_RXMATCH = 4'b0101,
    SWRSL_SRCH = 4'b0110,
    SWRSL_FUNC = 4'b0111,
    SWRSL_DEAD = 4'b1000
  } swrsl_state_e;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } swrsl_byte_s;

  typedef struct packed {
    logic slotStart;
    logic bitValue;
    logic resetSeen;
    logic longReset;
  } swrsl_slot_s;

endpackage : swrsl_pkg

/* logic/swrsl_fifo.sv */
// Small flip-flop FIFO carrying received function-command bytes.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module swrsl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Fill side.
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Drain side.
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  always_comb begin
    push = inValid && (cnt_q != (AW+1)'(DEPTH));
    pop = outReady && (cnt_q != '0);
    wr_d = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d = pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
    if (push) begin
      mem_q[wr_q] <= inData;
    end
  end

  assign inReady = (cnt_q != (AW+1)'(DEPTH));
  assign outValid = (cnt_q != '0);
  assign outData = mem_q[rd_q];
endmodule : swrsl_fifo

/* logic/swrsl_slot.sv */
// Line front end: synchronises the wire, times low pulses, reports slots and resets.
// Assumes the wire level is an asynchronous pin input.
`timescale 1ns/1ps
`include "swrsl_defs.svh"
module swrsl_slot (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Line and speed.
  input wire logic lineIn,
  input wire logic fastSpeed,
  // Decoded events.
  output swrsl_pkg::swrsl_slot_s ev,
  output logic lineHigh
);
  import swrsl_pkg::*;
  localparam int CW = 20;
  localparam logic [CW-1:0] STD_RST = CW'(`SWRSL_CYC(`SWRSL_STD_RESET_NS));
  localparam logic [CW-1:0] OD_RST = CW'(`SWRSL_CYC(`SWRSL_OD_RESET_NS));
  localparam logic [CW-1:0] OD_EXIT = CW'(`SWRSL_CYC(`SWRSL_OD_EXIT_NS));
  localparam logic [CW-1:0] STD_SMP = CW'(`SWRSL_CYC(`SWRSL_STD_SAMPLE_NS));
  localparam logic [CW-1:0] OD_SMP = CW'(`SWRSL_CYC(`SWRSL_OD_SAMPLE_NS));

  logic s1_q, s2_q, s3_q;
  logic [CW-1:0] low_q, low_d;
  swrsl_slot_s ev_d;
  logic [CW-1:0] smp;

  always_comb begin
    smp = fastSpeed ? OD_SMP : STD_SMP;
    low_d = s2_q ? '0 : ((low_q == '1) ? low_q : low_q + 1'b1);
    ev_d = '0;
    ev_d.slotStart = !s2_q && s3_q;
    // The written bit is sampled at a fixed point after the fall.
    if (!s2_q && low_q == smp) begin
      ev_d.bitValue = 1'b0;
    end
    if (s2_q && !s3_q) begin
      ev_d.bitValue = (low_q < smp);
      ev_d.resetSeen = low_q >= (fastSpeed ? OD_RST : STD_RST);
      ev_d.longReset = low_q >= OD_EXIT;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      low_q <= '0;
      ev <= '0;
    end else begin
      s1_q <= lineIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      low_q <= low_d;
      ev <= ev_d;
    end
  end

  assign lineHigh = s3_q;
endmodule : swrsl_slot

/* logic/swrsl_core.sv */
// Single-wire selection layer: presence, selection commands, resume and speed flags.
// Assumes an external pull-up on the line and a 125 MHz clock.
//
// Summary of operation
// - Reset pulse answered by presence pulse.
// - Exactly eight-bit selection command after presence.
// - Read command shifts out 64-bit identity.
// - Match compares 64 bits, else idle.
// - Search: true, complement, master bit, drop out.
// - Conditional search only when alarm flag set.
// - Brownout always counts, others when enabled.
// - Completed search selects like a match.
// - Skip goes straight to function handling.
// - Resume selects only while resume flag set.
// - Resume flag set by match/search/overdrive-match.
// - Other device selected clears resume flag.
// - Overdrive skip sets fast flag, selects.
// - Reset of 690us clears fast flag.
// - Short overdrive reset keeps fast flag.
// - Overdrive match sets fast flag on the command byte, before the compare.
// - Standard timing unless fast flag set.
// - Presence after wait, held presence-low time.
// - Falling edge starts internal slot timing.
`timescale 1ns/1ps
`include "swrsl_defs.svh"
module swrsl_core #(
  parameter logic [63:0] REG_ID = 64'h5a00_0000_0000_0141,  // Arbitrary value.
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Open-drain line, enable low while pulling low.
  input wire logic lineIn,
  output logic lineOut,
  output logic lineOe_n,
  // Alarm status location and its enables.
  input wire logic [7:0] alarm_flag_register,
  input wire logic [4:0] alarmEnable,
  // Function command bytes toward the memory layer.
  output swrsl_pkg::swrsl_byte_s funcByte,
  input wire logic funcReady,
  // Status.
  output logic fastSpeedFlag,
  output logic resumeSelectFlag,
  output logic selected
);
  import swrsl_pkg::*;

  // ----------------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------------
  localparam int CW = 16;
  localparam logic [CW-1:0] STD_PDH = CW'(`SWRSL_CYC(`SWRSL_STD_PDH_NS));
  localparam logic [CW-1:0] STD_PDL = CW'(`SWRSL_CYC(`SWRSL_STD_PDL_NS));
  localparam logic [CW-1:0] OD_PDH = CW'(`SWRSL_CYC(`SWRSL_OD_PDH_NS));
  localparam logic [CW-1:0] OD_PDL = CW'(`SWRSL_CYC(`SWRSL_OD_PDL_NS));
  localparam logic [CW-1:0] STD_HOLD = CW'(`SWRSL_CYC(`SWRSL_STD_HOLD_NS));
  localparam logic [CW-1:0] OD_HOLD = CW'(`SWRSL_CYC(`SWRSL_OD_HOLD_NS));

  function automatic logic alarmQualifies(input logic [7:0] flags, input logic [4:0] en);
    logic [4:0] gate;
    gate = en;
    gate[`SWRSL_ALARM_BROWNOUT_BIT] = 1'b1;
    return |(flags[`SWRSL_ALARM_FLAGS-1:0] & gate);
  endfunction : alarmQualifies

  // ----------------------------------------------------------------------
  // Front end.
  // ----------------------------------------------------------------------
  swrsl_slot_s ev;
  logic lineHigh;
  logic slotEnd, slotBit, slotReset, slotLong;
  logic endSeen_q;

  swrsl_slot u_slot (
    .clock(clock),
    .rst_n(rst_n),
    .lineIn(lineIn),
    .fastSpeed(fastSpeedFlag),
    .ev(ev),
    .lineHigh(lineHigh)
  );

  // ----------------------------------------------------------------------
  // Byte path to the function layer.
  // ----------------------------------------------------------------------
  logic fifoInValid, fifoInReady, fifoOutValid;
  logic funcOutReady;
  logic [7:0] sh_q, sh_d;
  logic [7:0] fifoOutData;

  swrsl_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .inValid(fifoInValid),
    .inData(sh_q),
    .inReady(fifoInReady),
    .outValid(fifoOutValid),
    .outData(fifoOutData),
    .outReady(funcOutReady)
  );

  // ----------------------------------------------------------------------
  // Selection state machine.
  // ----------------------------------------------------------------------
  swrsl_state_e st_q, st_d;
  logic [CW-1:0] tmr_q, tmr_d;
  logic [6:0] bit_q, bit_d;
  logic [1:0] phase_q, phase_d;
  logic od_q, od_d, rc_q, rc_d, drive_q, drive_d;
  logic [CW-1:0] holdCnt_q, holdCnt_d;
  logic sel_q, sel_d;
  swrsl_byte_s fb_q, fb_d;
  logic curBit;

  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    sh_d = sh_q;
    bit_d = bit_q;
    phase_d = phase_q;
    od_d = od_q;
    rc_d = rc_q;
    sel_d = sel_q;
    fifoInValid = 1'b0;
    curBit = REG_ID[bit_q[5:0]];
    holdCnt_d = (holdCnt_q != '0) ? holdCnt_q - 1'b1 : '0;
    drive_d = (holdCnt_q > 16'h0001);
    // Stall the drain only when the consumer is not ready.
    funcOutReady = !fb_q.valid || funcReady;
    fb_d = fb_q;
    if (funcReady) begin
      fb_d.valid = 1'b0;
    end
    if (funcOutReady && fifoOutValid) begin
      fb_d.valid = 1'b1;
      fb_d.data = fifoOutData;
    end
    // The falling edge starts the slot timer; a zero read holds the line.
    if (ev.slotStart && (st_q == SWRSL_TX || (st_q == SWRSL_SRCH && phase_q != 2'd2))) begin
      if (st_q == SWRSL_TX ? !curBit : (phase_q == 2'd0 ? !curBit : curBit)) begin
        holdCnt_d = od_q ? OD_HOLD : STD_HOLD;
        drive_d = 1'b1;
      end
    end
    case (st_q)
      SWRSL_PRES_WAIT: begin
        if (lineHigh) begin
          tmr_d = tmr_q + 1'b1;
          if (tmr_q >= (od_q ? OD_PDH : STD_PDH)) begin
            st_d = SWRSL_PRES_LOW;
            tmr_d = '0;
          end
        end
      end
      SWRSL_PRES_LOW: begin
        tmr_d = tmr_q + 1'b1;
        drive_d = (tmr_q < (od_q ? OD_PDL : STD_PDL));
        // Linger until our own release has passed the synchroniser, so it is not a slot.
        if (tmr_q >= (od_q ? OD_PDL : STD_PDL) + 16'h0010) begin
          st_d = SWRSL_CMD;
          bit_d = '0;
        end
      end
      SWRSL_CMD: begin
        if (ev.resetSeen == 1'b0 && ev.slotStart == 1'b0 && lineHigh && bit_q == 7'd8) begin
          bit_d = '0;
          phase_d = '0;
          case (sh_q)
            `SWRSL_CMD_READ: st_d = SWRSL_TX;
            `SWRSL_CMD_MATCH, `SWRSL_CMD_ODMATCH: st_d = SWRSL_RXMATCH;
            `SWRSL_CMD_SEARCH: st_d = SWRSL_SRCH;
            `SWRSL_CMD_CSEARCH: begin
              st_d = alarmQualifies(alarm_flag_register, alarmEnable) ? SWRSL_SRCH
                     : SWRSL_DEAD;
            end
            `SWRSL_CMD_SKIP: st_d = SWRSL_FUNC;
            `SWRSL_CMD_RESUME: st_d = rc_q ? SWRSL_FUNC : SWRSL_DEAD;
            `SWRSL_CMD_ODSKIP: begin
              od_d = 1'b1;
              st_d = SWRSL_FUNC;
            end
            default: st_d = SWRSL_DEAD;
          endcase
          if (sh_q == `SWRSL_CMD_ODMATCH) begin
            od_d = 1'b1;
          end
          if (sh_q != `SWRSL_CMD_RESUME && sh_q != `SWRSL_CMD_READ) begin
            rc_d = 1'b0;
          end
          sel_d = (st_d == SWRSL_FUNC);
        end else if (ev.bitValue || (ev.slotStart == 1'b0 && ev.resetSeen == 1'b0
                     && !lineHigh && 1'b0)) begin
          sh_d = sh_q;
        end
      end
      SWRSL_RXMATCH, SWRSL_SRCH: begin
        if (lineHigh && !ev.slotStart && bit_q == 7'd64) begin
          st_d = SWRSL_FUNC;
          sel_d = 1'b1;
          rc_d = 1'b1;
          bit_d = '0;
        end
      end
      SWRSL_FUNC: begin
        if (bit_q == 7'd8 && fifoInReady) begin
          fifoInValid = 1'b1;
          bit_d = '0;
        end
      end
      default: begin
      end
    endcase
    // Received bits are shifted least significant first on the rising edge.
    if (!ev.slotStart && ev.resetSeen == 1'b0 && (ev.bitValue || (lineHigh && 1'b0))) begin
      sh_d = sh_q;
    end
    if (st_q != SWRSL_PRES_WAIT && st_q != SWRSL_PRES_LOW && slotEnd) begin
      case (st_q)
        SWRSL_CMD, SWRSL_FUNC: begin
          if (bit_q != 7'd8) begin
            sh_d = {slotBit, sh_q[7:1]};
            bit_d = bit_q + 1'b1;
          end
        end
        SWRSL_RXMATCH: begin
          if (slotBit != curBit) begin
            st_d = SWRSL_DEAD;
          end
          bit_d = bit_q + 1'b1;
        end
        SWRSL_TX: begin
          bit_d = bit_q + 1'b1;
          if (bit_q == 7'd63) begin
            st_d = SWRSL_FUNC;
            bit_d = '0;
          end
        end
        SWRSL_SRCH: begin
          // Two read slots, then the slot carrying the master's chosen bit.
          phase_d = phase_q + 1'b1;
          if (phase_q == 2'd2) begin
            phase_d = '0;
            bit_d = bit_q + 1'b1;
            if (slotBit != curBit) begin
              st_d = SWRSL_DEAD;
            end
          end
        end
        default: begin
        end
      endcase
    end
    // A reset ends any sequence; only a long one leaves overdrive.
    if (slotEnd && slotReset) begin
      st_d = SWRSL_PRES_WAIT;
      tmr_d = '0;
      bit_d = '0;
      phase_d = '0;
      sel_d = 1'b0;
      holdCnt_d = '0;
      drive_d = 1'b0;
      if (slotLong) begin
        od_d = 1'b0;
      end
    end
  end

  // A slot ends on the rise of the synchronised line; the rise events arrive in that cycle.
  assign slotEnd = lineHigh && !endSeen_q;
  assign slotBit = ev.bitValue;
  assign slotReset = ev.resetSeen;
  assign slotLong = ev.longReset;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      endSeen_q <= 1'b1;
    end else begin
      endSeen_q <= lineHigh;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q <= SWRSL_IDLE;
      tmr_q <= '0;
      sh_q <= '0;
      bit_q <= '0;
      phase_q <= '0;
      od_q <= 1'b0;
      rc_q <= 1'b0;
      sel_q <= 1'b0;
      drive_q <= 1'b0;
      holdCnt_q <= '0;
      fb_q <= '0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      phase_q <= phase_d;
      od_q <= od_d;
      rc_q <= rc_d;
      sel_q <= sel_d;
      drive_q <= drive_d;
      holdCnt_q <= holdCnt_d;
      fb_q <= fb_d;
    end
  end

  assign lineOut = 1'b0;
  assign lineOe_n = !drive_q;
  assign fastSpeedFlag = od_q;
  assign resumeSelectFlag = rc_q;
  assign selected = sel_q;
  assign funcByte = fb_q;
endmodule : swrsl_core

/* test/swrsl_core_checker.sv */
// Assertions on the selection layer ports: presence timing, pull lengths, flag causes.
// Assumes it is bound onto swrsl_core; times follow swrsl_defs.svh.
`timescale 1ns/1ps
`include "swrsl_defs.svh"
module swrsl_core_checker (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Line.
  input wire logic lineIn,
  input wire logic lineOe_n,
  // Function bytes and status.
  input wire swrsl_pkg::swrsl_byte_s funcByte,
  input wire logic funcReady,
  input wire logic fastSpeedFlag,
  input wire logic resumeSelectFlag,
  input wire logic selected
);
  import swrsl_pkg::*;
  localparam int ODPDH = `SWRSL_CYC(`SWRSL_OD_PDH_NS);
  localparam int STPDH = `SWRSL_CYC(`SWRSL_STD_PDH_NS);
  localparam int ODPDL = `SWRSL_CYC(`SWRSL_OD_PDL_NS);
  localparam int STPDL = `SWRSL_CYC(`SWRSL_STD_PDL_NS);
  localparam int ODHLD = `SWRSL_CYC(`SWRSL_OD_HOLD_NS);
  localparam int STHLD = `SWRSL_CYC(`SWRSL_STD_HOLD_NS);
  localparam int EXIT = `SWRSL_CYC(`SWRSL_OD_EXIT_NS) - 8;
  logic [19:0] lowRun_q, lowRun_d, highRun_q, highRun_d, oeLow_q, oeLow_d;
  // ----------
  // Run lengths of the wire low, the wire high and the device's own pull.
  // ----------
  always_comb begin
    lowRun_d = lineIn ? 20'h0 : lowRun_q + 20'h1;
    highRun_d = lineIn ? highRun_q + 20'h1 : 20'h0;
    oeLow_d = lineOe_n ? 20'h0 : oeLow_q + 20'h1;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lowRun_q <= 20'h0;
      highRun_q <= 20'h0;
      oeLow_q <= 20'h0;
    end else begin
      lowRun_q <= lowRun_d;
      highRun_q <= highRun_d;
      oeLow_q <= oeLow_d;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_quiet;
    lineOe_n && !selected && !fastSpeedFlag && !resumeSelectFlag && !funcByte.valid;
  endsequence
  sequence s_selSoon;
    ##[0:4] selected;
  endsequence
  property p_rstQuiet;
    $rose(rst_n) |-> s_quiet;
  endproperty
  a_rstQuiet: assert property (p_rstQuiet) else $error("state not cleared by reset");
  property p_presWait;
    $fell(lineOe_n) && highRun_q != 0 |-> fastSpeedFlag ?
      highRun_q inside {[ODPDH-2:ODPDH+8]} : highRun_q inside {[STPDH-2:STPDH+8]};
  endproperty
  a_presWait: assert property (p_presWait) else $error("presence wait wrong");
  property p_pullLen;
    $rose(lineOe_n) |-> fastSpeedFlag ?
      oeLow_q inside {[ODPDL-4:ODPDL+4], [ODHLD-8:ODHLD+4]} :
      oeLow_q inside {[STPDL-4:STPDL+4], [STHLD-8:STHLD+4]};
  endproperty
  a_pullLen: assert property (p_pullLen) else $error("pull length wrong");
  property p_slotPull;
    $fell(lineOe_n) && highRun_q == 0 |-> lowRun_q <= 8;
  endproperty
  a_slotPull: assert property (p_slotPull) else $error("pull not tied to slot");
  property p_fastExit;
    $fell(fastSpeedFlag) |-> lowRun_q >= EXIT || $past(lowRun_q, 6) >= EXIT;
  endproperty
  a_fastExit: assert property (p_fastExit) else $error("overdrive left early");
  property p_fastSel;
    $rose(fastSpeedFlag) |-> s_selSoon;
  endproperty
  a_fastSel: assert property (p_fastSel) else $error("overdrive without select");
  property p_resumeSel;
    $rose(resumeSelectFlag) |-> s_selSoon;
  endproperty
  a_resumeSel: assert property (p_resumeSel) else $error("resume flag without select");
  property p_funcHold;
    funcByte.valid && !funcReady |=> funcByte.valid && $stable(funcByte.data);
  endproperty
  a_funcHold: assert property (p_funcHold) else $error("function byte not held");
endmodule : swrsl_core_checker

bind swrsl_core swrsl_core_checker u_chk (.clock(clock), .rst_n(rst_n), .lineIn(lineIn),
  .lineOe_n(lineOe_n), .funcByte(funcByte), .funcReady(funcReady),
  .fastSpeedFlag(fastSpeedFlag), .resumeSelectFlag(resumeSelectFlag), .selected(selected));

/* test/swrsl_master.sv */
// Bus master model: resets and bit slots on the single open-drain line.
// Assumes a pull-up, the device's enable-low pull and a 125 MHz clock.
`timescale 1ns/1ps
module swrsl_master (
  // Clock.
  input wire logic clock,
  // Line.
  input wire logic lineOe_n,
  output logic lineIn
);
  logic pullLow;
  logic fast;
  initial begin
    pullLow = 1'b0;
    fast = 1'b0;
  end
  // The pull-up wins only when neither side pulls low.
  assign lineIn = !(pullLow || !lineOe_n);
  task automatic waitCyc(input int n);
    repeat (n) @(negedge clock);
  endtask : waitCyc
  task automatic busReset(input int lowCyc, output logic seen);
    pullLow = 1'b1;
    waitCyc(lowCyc);
    pullLow = 1'b0;
    waitCyc(fast ? 625 : 5000);
    seen = !lineIn;
    // Single device on the bus, so the shorter window is enough.
    waitCyc(fast ? 1875 : 6250);
  endtask : busReset
  task automatic writeBit(input logic b);
    pullLow = 1'b1;
    waitCyc(b ? (fast ? 63 : 250) : (fast ? 500 : 4375));
    pullLow = 1'b0;
    waitCyc(b ? (fast ? 562 : 7500) : (fast ? 125 : 3750));
  endtask : writeBit
  task automatic readBit(output logic b);
    pullLow = 1'b1;
    waitCyc(fast ? 63 : 250);
    pullLow = 1'b0;
    waitCyc(fast ? 125 : 1250);
    b = lineIn;
    waitCyc(fast ? 500 : 6250);
  endtask : readBit
  task automatic sendByte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      writeBit(v[i]);
    end
  endtask : sendByte
  task automatic sendId(input logic [63:0] v);
    for (int i = 0; i < 8; i++) begin
      sendByte(v[8*i +: 8]);
    end
  endtask : sendId
endmodule : swrsl_master

/* test/single_wire_rom_select_layer_bench.sv */
// Self-checking bench: selection commands driven through the bus master model.
// Assumes the checker binds itself onto swrsl_core.
`timescale 1ns/1ps
`include "swrsl_defs.svh"
module single_wire_rom_select_layer_bench;
  import swrsl_pkg::*;
  localparam logic [63:0] ID = 64'h3c00_00a5_9e71_2b28; // Arbitrary value.
  localparam logic [7:0] AL [4] = '{8'h00, 8'h02, 8'h01, 8'h04};
  localparam logic [4:0] EN [4] = '{5'h00, 5'h00, 5'h00, 5'h04};
  localparam logic [3:0] PART = 4'b1100;
  logic clock, rst_n, lineIn, lineOut, lineOe_n, funcReady, seen, b0, b1;
  logic fastSpeedFlag, resumeSelectFlag, selected;
  logic [7:0] alarmReg;
  logic [4:0] alarmEnable;
  logic [63:0] got;
  swrsl_byte_s funcByte;
  int numErrors, samplesChecked;
  swrsl_core #(.REG_ID(ID), .FIFO_DEPTH(4)) DUT (.clock(clock), .rst_n(rst_n),
    .lineIn(lineIn), .lineOut(lineOut), .lineOe_n(lineOe_n),
    .alarm_flag_register(alarmReg), .alarmEnable(alarmEnable), .funcByte(funcByte),
    .funcReady(funcReady), .fastSpeedFlag(fastSpeedFlag),
    .resumeSelectFlag(resumeSelectFlag), .selected(selected));
  swrsl_master master (.clock(clock), .lineOe_n(lineOe_n), .lineIn(lineIn));
  initial clock = 1'b0;
  always #4 clock = ~clock;
  task automatic checkBit(input logic g, input logic e, input string what);
    samplesChecked++;
    if (g !== e) begin
      numErrors++;
      $display("ERROR %0t: %s got %b expected %b", $time, what, g, e);
    end
  endtask : checkBit
  task automatic checkWord(input logic [63:0] g, input logic [63:0] e, input string what);
    samplesChecked++;
    if (g !== e) begin
      numErrors++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask : checkWord
  task automatic results;
    $display("checks %0d errors %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  task automatic restart(input int lowCyc);
    master.busReset(lowCyc, seen);
    checkBit(seen, 1'b1, "presence pulse");
  endtask : restart
  task automatic access(input logic [7:0] cmd, input logic sendId);
    restart(6250);
    master.sendByte(cmd);
    if (sendId) begin
      master.sendId(ID);
    end
  endtask : access
  task automatic popByte(input logic [7:0] e);
    int n;
    n = 0;
    while (funcByte.valid !== 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    checkWord({56'h0, funcByte.data}, {56'h0, e}, "function byte");
    funcReady = 1'b1;
    @(negedge clock);
    funcReady = 1'b0;
  endtask : popByte
  initial begin
    rst_n = 1'b0;
    funcReady = 1'b0;
    alarmReg = 8'h00;
    alarmEnable = 5'h00;
    numErrors = 0;
    samplesChecked = 0;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    restart(62500);
    checkBit(lineOut, 1'b0, "open-drain data level");
    checkBit(fastSpeedFlag, 1'b0, "standard speed");
    master.sendByte(`SWRSL_CMD_ODSKIP);
    checkBit(fastSpeedFlag, 1'b1, "overdrive set");
    checkBit(selected, 1'b1, "overdrive skip selects");
    master.fast = 1'b1;
    master.sendByte(8'ha1);
    master.sendByte(8'h5c);
    popByte(8'ha1);
    popByte(8'h5c);
    $display("test overdrive skip done");
    access(`SWRSL_CMD_READ, 1'b0);
    checkBit(fastSpeedFlag, 1'b1, "short reset keeps overdrive");
    for (int i = 0; i < 64; i++) begin
      master.readBit(got[i]);
    end
    checkWord(got, ID, "identity read");
    $display("test read done");
    access(`SWRSL_CMD_MATCH, 1'b1);
    checkBit(selected, 1'b1, "match selects");
    checkBit(resumeSelectFlag, 1'b1, "resume flag set");
    access(`SWRSL_CMD_RESUME, 1'b0);
    checkBit(selected, 1'b1, "resume selects");
    access(`SWRSL_CMD_ODMATCH, 1'b1);
    checkBit(selected, 1'b1, "overdrive match selects");
    checkBit(fastSpeedFlag, 1'b1, "overdrive kept by match");
    restart(6250);
    master.sendByte(`SWRSL_CMD_MATCH);
    master.sendId(ID ^ 64'h8000_0000_0000_0000);
    checkBit(selected, 1'b0, "mismatch idles");
    checkBit(resumeSelectFlag, 1'b0, "resume flag cleared");
    access(`SWRSL_CMD_RESUME, 1'b0);
    checkBit(selected, 1'b0, "resume refused");
    access(8'h00, 1'b0);
    master.sendByte(`SWRSL_CMD_SKIP);
    checkBit(selected, 1'b0, "unknown code ignored");
    access(`SWRSL_CMD_SKIP, 1'b0);
    checkBit(selected, 1'b1, "skip selects");
    checkBit(resumeSelectFlag, 1'b0, "skip leaves resume flag");
    $display("test select done");
    for (int k = 0; k < 4; k++) begin
      alarmReg = AL[k];
      alarmEnable = EN[k];
      access(`SWRSL_CMD_CSEARCH, 1'b0);
      master.readBit(b0);
      master.readBit(b1);
      checkBit(b0, PART[k] ? ID[0] : 1'b1, "search true bit");
      checkBit(b1, PART[k] ? !ID[0] : 1'b1, "search complement bit");
      if (k == 3) begin
        master.writeBit(!ID[0]);
        master.readBit(b0);
        checkBit(b0, 1'b1, "dropped out of search");
      end
    end
    $display("test search done");
    master.fast = 1'b0;
    restart(87500);
    checkBit(fastSpeedFlag, 1'b0, "long reset exits overdrive");
    $display("test speed done");
    results();
  end
  initial begin
    #8000000;
    numErrors++;
    $display("ERROR %0t: watchdog expired", $time);
    results();
  end
endmodule : single_wire_rom_select_layer_bench
